// [verilog/sps_supervisor.sv]
/*
 * supply supervisor: reset generation with a minimum hold, low-supply
 * flag, backup source selection, backup-mode output forcing and
 * memory chip-select gating.
 * assumes comparator decisions, the timebase pin, the power-fail sense
 * and the watchdog expiry pin all come from outside the clock domain; the
 * incoming chip-select is likewise synchronised, adding two cycles.
 */
// Notes on behaviour
// - reset asserted while supply below threshold
// - reset held minimum time after recovery
// - adjustable variants select hold duration
// - active-high reset inverts active-low reset
// - low-supply flag follows comparator, no hold delay
// - source switches with 70/50 mV hysteresis
// - backup indicator high while on battery
// - backup: power-fail warning forced low
// - backup: reset low, flag low, timebase ignored
// - backup: watchdog kick ignored, expiry high
// - valid supply passes chip-select through
// - invalid supply forces chip-select high
// - backup disregards incoming chip-select
module sps_supervisor #(
    parameter bit LONG_HOLD = 1'b0,
    parameter bit ADJUSTABLE = 1'b1,
    parameter int unsigned TB_DIVIDE = sps_pkg::TB_DIV
) (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RESET,
    // comparator decisions
    input wire logic SUPPLY_BELOW_THRESHOLD,
    input wire logic SOURCE_ABOVE_SWITCH_HI,
    input wire logic SOURCE_BELOW_SWITCH_LO,
    // timebase selection
    input wire logic TIMEBASE_SOURCE_SELECT,
    input wire logic TIMEBASE_EXTERNAL_INPUT,
    // power-fail and watchdog
    input wire logic POWERFAIL_SENSE_INPUT,
    input wire logic WATCHDOG_KICK_INPUT,
    input wire logic WATCHDOG_EXPIRED,
    // memory chip-select, active low
    input wire logic CHIP_SELECT_IN_N,
    output logic CHIP_SELECT_OUT_N,
    // reset and status outputs
    output logic PROC_RESET_N,
    output logic PROC_RESET,
    output logic LOW_SUPPLY_N,
    output logic BACKUP_ACTIVE_INDICATOR,
    output logic POWERFAIL_WARNING_OUTPUT_N,
    output logic WATCHDOG_EXPIRY_OUTPUT_N
);
    import sps_pkg::*;


    // elaboration checks: divider and hold counts must fit their counters
    initial begin
        if (TB_DIVIDE < 2 || TB_DIVIDE >= (1 << DIV_W)) begin
            $error("TB_DIVIDE out of range");
        end
        if (HOLD_LONG_TICKS >= (1 << HOLD_W)) begin
            $error("internal hold count too wide");
        end
        if (HOLD_SHORT_TICKS >= (1 << HOLD_W)) begin
            $error("internal short hold count too wide");
        end
        if (HOLD_EXT_LONG_CLKS >= (1 << HOLD_W)) begin
            $error("external hold count too wide");
        end
        if (HOLD_EXT_SHORT_CLKS >= (1 << HOLD_W)) begin
            $error("external short hold count too wide");
        end
    end

    // hold reload values, picked once per variant

    localparam logic [HOLD_W-1:0] HOLD_INT = LONG_HOLD ?
        HOLD_W'(HOLD_LONG_TICKS) : HOLD_W'(HOLD_SHORT_TICKS);
    localparam logic [HOLD_W-1:0] HOLD_EXT = LONG_HOLD ?
        HOLD_W'(HOLD_EXT_LONG_CLKS) : HOLD_W'(HOLD_EXT_SHORT_CLKS);
    // last divider count before the internal tick
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TB_DIVIDE - 1);

    // whole state of the block in one packed word

    typedef struct packed {
        logic [7:0] sync1;
        logic [7:0] sync2;
        logic ext_prev;
        logic [DIV_W-1:0] div;
        logic [HOLD_W-1:0] hold;
        sps_state_e state;
        logic on_batt;
        logic rst_n; // processor reset, active low
        logic rst; // processor reset, active high
        logic low_n; // low-supply flag
        logic bkp_ind; // backup indicator
        logic pfw_n; // power-fail warning
        logic wde_n; // watchdog expiry
        logic ce_n; // gated chip-select
    } sps_s;

    sps_s st_reg;
    sps_s st_next;

    // power-up image: reset asserted, source on main, memory locked out;
    // the hold is reloaded on leaving the low state, so a host reset
    // behaves like a fresh power-up and applies the full hold time
    localparam sps_s ST_RESET = '{
        sync1: 8'h00,
        sync2: 8'h00,
        ext_prev: 1'b0,
        div: '0,
        hold: '0,
        state: SPS_LOW,
        on_batt: 1'b0,
        rst_n: 1'b0,
        rst: 1'b1,
        low_n: 1'b0,
        bkp_ind: 1'b0,
        pfw_n: 1'b0,
        wde_n: 1'b1,
        ce_n: 1'b1
    };

    // external timebase in force: adjustable variants with select low
    function automatic logic ext_selected(input logic sel_sync);
        return ADJUSTABLE && !sel_sync;
    endfunction

    // hold reload for the timebase in force
    function automatic logic [HOLD_W-1:0] hold_load(input logic ext);
        return ext ? HOLD_EXT : HOLD_INT;
    endfunction

    // synchroniser bit positions
    localparam int unsigned S_BELOW = 0;
    localparam int unsigned S_HI = 1;
    localparam int unsigned S_LO = 2;
    localparam int unsigned S_SEL = 3;
    localparam int unsigned S_EXT = 4;
    localparam int unsigned S_PFS = 5;
    localparam int unsigned S_WD = 6;
    localparam int unsigned S_CE = 7;

    // whole next-state computation
    always_comb begin
        logic below;
        logic tick;
        logic batt;
        logic [7:0] pins;
        below = 1'b0;
        tick = 1'b0;
        batt = 1'b0;
        // pin order follows the synchroniser bit positions above
        pins = {CHIP_SELECT_IN_N,
                WATCHDOG_EXPIRED,
                POWERFAIL_SENSE_INPUT,
                TIMEBASE_EXTERNAL_INPUT,
                TIMEBASE_SOURCE_SELECT,
                SOURCE_BELOW_SWITCH_LO,
                SOURCE_ABOVE_SWITCH_HI,
                SUPPLY_BELOW_THRESHOLD};
        // default: every field keeps its value
        st_next = st_reg;
        // two-stage synchronisers; only stage two is read
        st_next.sync1 = pins;
        st_next.sync2 = st_reg.sync1;
        below = st_reg.sync2[S_BELOW];

        // source switching with hysteresis: hold between thresholds
        batt = st_reg.on_batt;
        if (st_reg.sync2[S_HI]) begin
            batt = 1'b0;
        end else if (st_reg.sync2[S_LO]) begin
            batt = 1'b1;
        end
        st_next.on_batt = batt;

        // timebase: internal divider, or external edges when selected
        st_next.ext_prev = st_reg.sync2[S_EXT];
        if (st_reg.div == DIV_LAST) begin
            st_next.div = '0;
        end else begin
            st_next.div = st_reg.div + 1'b1;
        end
        // edge detector starts at zero, as does its synchroniser, so no
        // false edge follows reset
        if (ext_selected(st_reg.sync2[S_SEL])) begin
            tick = st_reg.sync2[S_EXT] && !st_reg.ext_prev;
        end else begin
            tick = (st_reg.div == DIV_LAST);
        end

        // hold sequencer; backup wins over everything
        // low: supply below threshold, reset asserted
        // hold: supply back, reset kept until the count runs out
        // run: reset released
        // backup: on battery, all outputs forced
        // a dip during hold goes back to low, so the count restarts
        case (st_reg.state)
            SPS_BACKUP: begin
                if (!batt) begin
                    st_next.state = SPS_LOW;
                end
            end
            SPS_LOW: begin
                if (batt) begin
                    st_next.state = SPS_BACKUP;
                end else if (!below) begin
                    st_next.state = SPS_HOLD;
                    // reload picked for the timebase selected now; the tick source is not latched
                    st_next.hold = hold_load(
                        ext_selected(st_reg.sync2[S_SEL]));
                end
            end
            SPS_HOLD: begin
                if (batt) begin
                    st_next.state = SPS_BACKUP;
                end else if (below) begin
                    st_next.state = SPS_LOW;
                end else if (st_reg.hold == '0) begin
                    st_next.state = SPS_RUN;
                end else if (tick) begin
                    st_next.hold = st_reg.hold - 1'b1;
                end
            end
            SPS_RUN: begin
                if (batt) begin
                    st_next.state = SPS_BACKUP;
                end else if (below) begin
                    st_next.state = SPS_LOW;
                end
            end
            default: st_next.state = SPS_LOW;
        endcase

        // outputs; backup forcing of each pin
        // in backup the sense and watchdog pins are not read, and the select and
        // timebase pins feed only the tick and the hold reload, unused there, so a floating pin cannot disturb the outputs
        if (batt) begin
            st_next.rst_n = 1'b0;
            st_next.low_n = 1'b0;
            st_next.pfw_n = 1'b0;
            st_next.wde_n = 1'b1;
            st_next.ce_n = 1'b1;
        end else begin
            // reset released only once the hold has run out
            st_next.rst_n = !below && st_next.state == SPS_RUN;
            // flag follows the comparator with no hold delay
            st_next.low_n = !below;
            st_next.pfw_n = st_reg.sync2[S_PFS];
            // expiry cleared when the supply goes low
            st_next.wde_n = below || !st_reg.sync2[S_WD];
            // select is two cycles late: a limitation of synchronising it
            if (below) begin
                st_next.ce_n = 1'b1;
            end else begin
                st_next.ce_n = st_reg.sync2[S_CE];
            end
        end
        // taken from the same next value, so the pair never disagrees
        st_next.rst = !st_next.rst_n;
        st_next.bkp_ind = batt;
    end

    // register the whole state; reset looks like a fresh power-up
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            st_reg <= ST_RESET;
        end else begin
            st_reg <= st_next;
        end
    end


    // reset pair, straight from flip-flops
    assign PROC_RESET_N = st_reg.rst_n;
    assign PROC_RESET = st_reg.rst;

    // supply status, straight from flip-flops
    assign LOW_SUPPLY_N = st_reg.low_n;
    assign BACKUP_ACTIVE_INDICATOR = st_reg.bkp_ind;

    // warning outputs, straight from flip-flops
    assign POWERFAIL_WARNING_OUTPUT_N = st_reg.pfw_n;
    assign WATCHDOG_EXPIRY_OUTPUT_N = st_reg.wde_n;

    // gated memory select; glitch free since it is registered
    assign CHIP_SELECT_OUT_N = st_reg.ce_n;
endmodule

// [common/sps_pkg.sv]
/*
 * constants for the supply supervisor and reset gating block.
 * assumes a 20 MHz system clock; comparator decisions arrive as pins.
 */
package sps_pkg;
    // system clock
    localparam int unsigned CLK_HZ = 20_000_000;
    // hold times in microseconds, as minimum figures
    localparam int unsigned HOLD_SHORT_US = 35_000;
    localparam int unsigned HOLD_LONG_US = 140_000;
    // internal timebase: 10.24 kHz nominal, so one tick every 1953 clocks
    localparam int unsigned TB_TICK_HZ = 10_240;
    localparam int unsigned TB_DIV = CLK_HZ / TB_TICK_HZ;
    // least times round up to whole timebase ticks
    localparam int unsigned HOLD_SHORT_TICKS =
        (HOLD_SHORT_US * (TB_TICK_HZ / 10) + 99_999) / 100_000;
    localparam int unsigned HOLD_LONG_TICKS =
        (HOLD_LONG_US * (TB_TICK_HZ / 10) + 99_999) / 100_000;
    // external timebase counts for the adjustable variants
    localparam int unsigned HOLD_EXT_SHORT_CLKS = 512;
    localparam int unsigned HOLD_EXT_LONG_CLKS = 2048;
    // hold counter width and divider width
    localparam int unsigned HOLD_W = 12;
    localparam int unsigned DIV_W = 12;
    // hold sequencer states
    typedef enum logic [1:0] {
        SPS_BACKUP = 2'b00,
        SPS_LOW = 2'b01,
        SPS_HOLD = 2'b10,
        SPS_RUN = 2'b11
    } sps_state_e;
endpackage

// [dv/sps_supervisor_sva.sv]
/* checks on the supervisor outputs.
   assumes outputs lag inputs by three edges. */
module sps_supervisor_sva #(
    parameter bit LONG_HOLD = 1'b0,
    parameter int unsigned TB_DIVIDE = 4
) (
    // clock, reset and inputs
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire logic SUPPLY_BELOW_THRESHOLD,
    input wire logic SOURCE_ABOVE_SWITCH_HI,
    input wire logic SOURCE_BELOW_SWITCH_LO,
    input wire logic TIMEBASE_SOURCE_SELECT,
    input wire logic CHIP_SELECT_IN_N,
    // outputs
    input wire logic CHIP_SELECT_OUT_N,
    input wire logic PROC_RESET_N,
    input wire logic PROC_RESET,
    input wire logic LOW_SUPPLY_N,
    input wire logic BACKUP_ACTIVE_INDICATOR,
    input wire logic POWERFAIL_WARNING_OUTPUT_N,
    input wire logic WATCHDOG_EXPIRY_OUTPUT_N
);
    timeunit 1ns;
    timeprecision 1ps;
    import sps_pkg::*;
    localparam int HT = TB_DIVIDE *
        (LONG_HOLD ? HOLD_LONG_TICKS : HOLD_SHORT_TICKS);
    logic [2:0] st_reg;
    logic [15:0] hc_reg;
    wire ok = st_reg == 3'h5;
    wire bat = BACKUP_ACTIVE_INDICATOR;
    // settle count keeps checks off the pipeline fill after reset
    always_ff @(posedge SYS_CLK) begin
        st_reg <= RESET ? 3'h0 : st_reg + 3'(st_reg != 3'h5);
        hc_reg <= LOW_SUPPLY_N ? hc_reg + 16'h1 : 16'h0;
    end
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RESET);
    chk_reset_low: assert property (ok && $past(SUPPLY_BELOW_THRESHOLD, 3)
        |-> !PROC_RESET_N) else $error("reset not low");
    chk_reset_pair: assert property (PROC_RESET != PROC_RESET_N)
        else $error("reset pair not inverse");
    chk_flag_fast: assert property (ok && !bat |->
        LOW_SUPPLY_N == !$past(SUPPLY_BELOW_THRESHOLD, 3))
        else $error("flag wrong");
    chk_hold_span: assert property ($rose(PROC_RESET_N) &&
        TIMEBASE_SOURCE_SELECT |-> hc_reg >= HT - TB_DIVIDE &&
        hc_reg <= HT + TB_DIVIDE + 4) else $error("hold length wrong");
    chk_source_batt: assert property (ok && !$past(SOURCE_ABOVE_SWITCH_HI, 3)
        && $past(SOURCE_BELOW_SWITCH_LO, 3) |-> bat) else $error("no backup");
    chk_source_main: assert property (ok &&
        $past(SOURCE_ABOVE_SWITCH_HI, 3) |-> !bat) else $error("not main");
    chk_backup_force: assert property (bat |-> !PROC_RESET_N &&
        !LOW_SUPPLY_N && !POWERFAIL_WARNING_OUTPUT_N &&
        WATCHDOG_EXPIRY_OUTPUT_N) else $error("backup outputs wrong");
    chk_cs_pass: assert property (ok && !bat &&
        !$past(SUPPLY_BELOW_THRESHOLD, 3) |->
        CHIP_SELECT_OUT_N == $past(CHIP_SELECT_IN_N, 3))
        else $error("select not passed");
    chk_cs_block: assert property (bat || ok &&
        $past(SUPPLY_BELOW_THRESHOLD, 3) |-> CHIP_SELECT_OUT_N)
        else $error("select not blocked");
    cover property (bat);
    cover property ($rose(PROC_RESET_N));
    cover property (!CHIP_SELECT_OUT_N);
endmodule
bind sps_supervisor sps_supervisor_sva #(.LONG_HOLD(LONG_HOLD),
    .TB_DIVIDE(TB_DIVIDE)) sps_supervisor_sva_i (.*);

// [dv/sps_host_ram.sv]
/* host decoder and battery-backed ram.
   assumes the bench drives the host address. */
module sps_host_ram (
    // host side
    input wire logic clk,
    input wire logic [3:0] addr,
    output logic cs_n,
    // ram side
    input wire logic cs_gated_n,
    output int hits
);
    timeunit 1ns;
    timeprecision 1ps;
    // ram sits in the upper half of the space
    assign cs_n = !addr[3];
    // count accesses that reach the ram
    int cnt = 0;
    always @(posedge clk) if (!cs_gated_n) cnt <= cnt + 1;
    assign hits = cnt;
endmodule

// [dv/sps_supervisor_bench.sv]
/* bench: random levels, backup entry and exit, hold on both timebases.
   assumes the host model and the bound checker. */
module sps_supervisor_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import sps_pkg::*;
    localparam int D = 4;
    logic clk, rst, below, hi, lo, sel, ext, pfs, kick, wdx;
    logic [3:0] addr;
    logic cs_n, cso_n, pr_n, pr, low_n, batt, pfw_n, wde_n;
    int errors, compares, hits, h, n;
    bit run;
    sps_supervisor #(.TB_DIVIDE(D)) sps_supervisor_i (.SYS_CLK(clk),
        .RESET(rst), .SUPPLY_BELOW_THRESHOLD(below),
        .SOURCE_ABOVE_SWITCH_HI(hi), .SOURCE_BELOW_SWITCH_LO(lo),
        .TIMEBASE_SOURCE_SELECT(sel), .TIMEBASE_EXTERNAL_INPUT(ext),
        .POWERFAIL_SENSE_INPUT(pfs), .WATCHDOG_KICK_INPUT(kick),
        .WATCHDOG_EXPIRED(wdx), .CHIP_SELECT_IN_N(cs_n),
        .CHIP_SELECT_OUT_N(cso_n), .PROC_RESET_N(pr_n), .PROC_RESET(pr),
        .LOW_SUPPLY_N(low_n), .BACKUP_ACTIVE_INDICATOR(batt),
        .POWERFAIL_WARNING_OUTPUT_N(pfw_n),
        .WATCHDOG_EXPIRY_OUTPUT_N(wde_n));
    sps_host_ram sps_host_ram_i (.clk(clk), .addr(addr), .cs_n(cs_n),
        .cs_gated_n(cso_n), .hits(hits));
    // 20 MHz clock; external timebase rises every second cycle
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) if (run) ext <= ~ext;
    task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
        compares++;
        if (s !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic close_out();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // hold span in cycles; phase slop is allowed by the caller
    function automatic int exp_hold(bit ex);
        return ex ? HOLD_EXT_SHORT_CLKS * 2 : HOLD_SHORT_TICKS * D;
    endfunction
    // dip the supply, count from flag release to reset release
    task automatic hold(bit ex, output int c);
        @(posedge clk);
        below <= 1'b1;
        sel <= !ex;
        run <= ex;
        lo <= 1'b0;
        repeat (6) @(posedge clk);
        below <= 1'b0;
        c = 0;
        for (int i = 0; i < 20 && !low_n; i++) @(posedge clk) #1;
        while (!pr_n && c < 9000) begin
            @(posedge clk) #1;
            c++;
        end
    endtask
    // run is cut short if it hangs
    initial begin
        #1_000_000;
        errors++;
        close_out();
    end
    initial begin
        {rst, below, hi, sel, pfs} = 5'h1f;
        {lo, ext, kick, wdx, run} = 5'h0;
        addr = 4'h0;
        void'($urandom(83));
        repeat (10) @(posedge clk);
        {rst, below} <= 2'h0;
        for (int i = 0; i < 320; i++) begin
            @(posedge clk);
            {below, pfs, wdx, kick, addr} <= 8'($urandom);
            if (i == 300) {hi, lo} <= 2'h1;
            if (i == 304) h = hits;
            repeat (4) @(posedge clk);
            #1;
            if (i < 300) begin
                chk("low", low_n, !below);
                chk("cso", cso_n, below | cs_n);
                chk("pair", pr, !pr_n);
                chk("pfw", pfw_n, pfs);
                chk("wde", wde_n, !wdx | below);
                if (below) chk("prst", pr_n, 1'b0);
            end else begin
                chk("force", {batt, pr_n, pr, low_n, pfw_n, wde_n, cso_n},
                    7'h53);
                run <= 1'($urandom);
                sel <= 1'($urandom);
            end
        end
        chk("ram", hits, h);
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            {hi, lo, run, sel} <= {2'(8'h23 >> (6 - 2 * k)), 2'h1};
            repeat (4) @(posedge clk);
            #1;
            chk("src", batt, k == 0);
        end
        for (int k = 1; k >= 0; k--) begin
            hold(k[0], n);
            chk("hold", n > exp_hold(k[0]) - 9 && n < exp_hold(k[0]) + 9, 1'b1);
        end
        close_out();
    end
endmodule
